// *** verilog/selwake_pkg.sv ***
// Shared constants and types for the selective-wake flag block
package selwake_pkg;

	// ----------------------------------------------------------------
	// Register word indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [6:0] IDX_STATUS = 7'h00;
	localparam logic [6:0] IDX_BUSCTRL = 7'h01;
	localparam logic [6:0] IDX_WKSTAT = 7'h02;
	localparam logic [6:0] IDX_SWKSTAT = 7'h03;
	localparam logic [6:0] IDX_SWKCTRL = 7'h04;
	localparam logic [6:0] IDX_ECNT = 7'h05;
	localparam logic [6:0] IDX_CFG_FIRST = 7'h21;
	localparam logic [6:0] IDX_CFG_LAST = 7'h33;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ST_POR = 0;
	localparam int ST_FAIL = 1;
	localparam int WK_CHAN = 0;
	localparam int SW_PAT = 0;
	localparam int SW_FRAME = 1;
	localparam int SW_ERR = 2;
	localparam int SW_TO = 3;
	localparam int SW_SIL = 4;
	localparam int SW_SYNC = 5;
	localparam int SW_ARMED = 6;
	localparam int CT_VALID = 0;
	localparam int CT_TOMASK = 1;

	// ----------------------------------------------------------------
	// Mode encoding and counter limits
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [1:0] LOW_OFF = 2'h0;
	localparam logic [1:0] LOW_WAKE = 2'h1;
	localparam logic [1:0] LOW_NORMAL = 2'h3;
	localparam logic [5:0] ECNT_LAST = 6'h1f;
	localparam logic [5:0] ECNT_ZERO = 6'h00;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	// Device operating mode, driven by the chip's mode controller
	typedef enum logic [1:0] {
		SBC_NORMAL,
		SBC_STOP,
		SBC_SLEEP,
		SBC_RESTART
	} sbc_mode_t;

	// One-cycle event pulses from the frame decoder and bus monitors
	typedef struct packed {
		logic wupSeen;
		logic frameMatch;
		logic validFrame;
		logic protoError;
		logic busEdge;
		logic busDomTimeout;
		logic txdDomTimeout;
	} bus_events_t;

endpackage

// *** verilog/can_selective_wake_flags.sv ***
// Selective-wake status flags, mode selection and register slave for one CAN channel
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module can_selective_wake_flags #(
	parameter int unsigned SILENCE_CYCLES = 200000,
	parameter int ADDR_W = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire selwake_pkg::sbc_mode_t sbcMode,
	input wire selwake_pkg::bus_events_t busEvents,
	output logic wakeIrq,
	output logic timeoutIrq,
	output logic restartReq,
	output logic transmitEnable,
	output logic receiveDeliver,
	output logic receiveWakeLow,
	output logic swkActive
);

	typedef enum logic [2:0] {
		DET_IDLE,
		DET_FRAME,
		DET_PAT1,
		DET_PAT2,
		DET_WOKEN
	} det_state_t;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	det_state_t detState_q;
	selwake_pkg::sbc_mode_t prevMode_q;
	logic waitReq_q;
	logic [31:0] readData_q;
	logic [2:0] modeBits_q;
	logic powerOn_q, fail_q, chanWake_q;
	logic patWake_q, frameWake_q, sysErr_q, busTimeout_q, silence_q, sync_q, armed_q;
	logic cfgValid_q, toMask_q, wokeByFrame_q;
	logic [5:0] ecnt_q;
	logic [31:0] silenceCnt_q;
	logic wakeIrq_q, timeoutIrq_q, restartReq_q;
	logic txEn_q, rxDel_q, rxLow_q, swkAct_q;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [6:0] idx;
	logic busWr, inNormal, awake, modeWr, cfgWr, swCtrlWr, enterSleep, enterRestart;
	logic newSwk, checkRun, checkOk, swkSel, chanOn, swkRun;
	logic silenceExpire, ecntOverflow, cfgErr, restartErr;
	logic frameWakeEv, patWakeSwk, patWakeWk, patDet1, anyWake, rearm, errClrReq;
	logic [2:0] modeWrVal;

	assign idx = avs_address[8:2];
	// A write takes effect at the edge that sees waitrequest low
	assign busWr = avs_write && !waitReq_q;
	assign inNormal = (sbcMode == selwake_pkg::SBC_NORMAL);
	assign awake = inNormal || (sbcMode == selwake_pkg::SBC_STOP);
	assign modeWrVal = avs_writedata[2:0];
	assign modeWr = busWr && (idx == selwake_pkg::IDX_BUSCTRL) && inNormal;
	assign cfgWr = busWr && inNormal && (idx >= selwake_pkg::IDX_CFG_FIRST) &&
		(idx <= selwake_pkg::IDX_CFG_LAST);
	assign swCtrlWr = busWr && (idx == selwake_pkg::IDX_SWKCTRL);
	assign errClrReq = busWr && (idx == selwake_pkg::IDX_SWKSTAT) &&
		avs_writedata[selwake_pkg::SW_ERR];
	assign enterSleep = (sbcMode == selwake_pkg::SBC_SLEEP) &&
		(prevMode_q != selwake_pkg::SBC_SLEEP);
	assign enterRestart = (sbcMode == selwake_pkg::SBC_RESTART) &&
		(prevMode_q != selwake_pkg::SBC_RESTART);
	assign newSwk = modeWrVal[2] && (modeWrVal[1:0] != selwake_pkg::LOW_OFF);
	assign checkRun = modeWr && newSwk;
	assign checkOk = checkRun && cfgValid_q;
	assign swkSel = modeBits_q[2] && (modeBits_q[1:0] != selwake_pkg::LOW_OFF);
	assign chanOn = (modeBits_q[1:0] != selwake_pkg::LOW_OFF);
	assign swkRun = (detState_q == DET_FRAME) || (detState_q == DET_PAT1);
	assign silenceExpire = ((detState_q == DET_FRAME) || (detState_q == DET_PAT2)) &&
		(silenceCnt_q == 32'(SILENCE_CYCLES - 1));
	assign ecntOverflow = (detState_q == DET_FRAME) && busEvents.protoError &&
		(ecnt_q == selwake_pkg::ECNT_LAST);
	assign cfgErr = cfgWr && swkSel && swkRun;
	assign restartErr = enterRestart && swkSel && swkRun && !wokeByFrame_q;
	assign frameWakeEv = (detState_q == DET_FRAME) && busEvents.frameMatch;
	assign patWakeSwk = (detState_q == DET_PAT2) && busEvents.wupSeen;
	assign patWakeWk = (detState_q == DET_IDLE) && chanOn && busEvents.wupSeen;
	assign patDet1 = (detState_q == DET_PAT1) && busEvents.wupSeen;
	assign anyWake = frameWakeEv || patWakeSwk || patWakeWk || ecntOverflow;
	// Any mode write or sleep entry rearms; sleep entry avoids a lock-up when already woken
	assign rearm = modeWr || enterSleep;

	// ----------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then the access completes
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waitReq_q <= 1'b1;
			readData_q <= selwake_pkg::RDATA_ZERO;
		end else if ((avs_read || avs_write) && waitReq_q) begin
			waitReq_q <= 1'b0;
			readData_q <= selwake_pkg::RDATA_ZERO;
			if (avs_read) begin
				unique case (idx)
					selwake_pkg::IDX_STATUS: begin
						readData_q[selwake_pkg::ST_POR] <= powerOn_q;
						readData_q[selwake_pkg::ST_FAIL] <= fail_q;
					end
					selwake_pkg::IDX_BUSCTRL: readData_q[2:0] <= modeBits_q;
					selwake_pkg::IDX_WKSTAT: readData_q[selwake_pkg::WK_CHAN] <= chanWake_q;
					selwake_pkg::IDX_SWKSTAT: begin
						readData_q[selwake_pkg::SW_PAT] <= patWake_q;
						readData_q[selwake_pkg::SW_FRAME] <= frameWake_q;
						readData_q[selwake_pkg::SW_ERR] <= sysErr_q;
						readData_q[selwake_pkg::SW_TO] <= busTimeout_q;
						readData_q[selwake_pkg::SW_SIL] <= silence_q;
						readData_q[selwake_pkg::SW_SYNC] <= sync_q;
						readData_q[selwake_pkg::SW_ARMED] <= armed_q;
					end
					selwake_pkg::IDX_SWKCTRL: begin
						readData_q[selwake_pkg::CT_VALID] <= cfgValid_q;
						readData_q[selwake_pkg::CT_TOMASK] <= toMask_q;
					end
					selwake_pkg::IDX_ECNT: readData_q[5:0] <= ecnt_q;
					default: readData_q <= selwake_pkg::RDATA_ZERO;
				endcase
			end
		end else begin
			waitReq_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prevMode_q <= selwake_pkg::SBC_NORMAL;
		end else begin
			prevMode_q <= sbcMode;
		end
	end

	// ----------------------------------------------------------------
	// Channel mode bits
	// ----------------------------------------------------------------
	// Low bits are rewritten on leaving Normal so readback reflects the mode really run
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeBits_q <= selwake_pkg::MODE_RESET;
		end else if (modeWr) begin
			modeBits_q <= modeWrVal;
		end else if ((sbcMode == selwake_pkg::SBC_STOP) && (prevMode_q != selwake_pkg::SBC_STOP) &&
			(modeBits_q[1:0] == selwake_pkg::LOW_NORMAL)) begin
			modeBits_q[1:0] <= selwake_pkg::LOW_WAKE;
		end else if ((enterSleep || enterRestart) && modeBits_q[1]) begin
			modeBits_q[1:0] <= selwake_pkg::LOW_WAKE;
		end
	end

	// ----------------------------------------------------------------
	// Detection state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			detState_q <= DET_IDLE;
		end else if (modeWr) begin
			if (checkRun) begin
				detState_q <= cfgValid_q ? DET_FRAME : DET_PAT2;
			end else begin
				detState_q <= DET_IDLE;
			end
		end else if (enterSleep && (detState_q == DET_WOKEN)) begin
			// sleep entry does not wait for sync
			detState_q <= (swkSel && !sysErr_q) ? DET_FRAME : DET_IDLE;
		end else if (restartErr) begin
			detState_q <= DET_PAT2;
		end else begin
			unique case (detState_q)
				DET_IDLE: if (patWakeWk) detState_q <= DET_WOKEN;
				DET_FRAME: begin
					if (frameWakeEv || ecntOverflow) begin
						detState_q <= DET_WOKEN;
					end else if (cfgErr) begin
						detState_q <= DET_PAT2;
					end else if (silenceExpire) begin
						detState_q <= DET_PAT1;
					end
				end
				DET_PAT1: begin
					if (cfgErr) begin
						detState_q <= DET_PAT2;
					end else if (patDet1) begin
						detState_q <= DET_FRAME;
					end
				end
				DET_PAT2: if (patWakeSwk) detState_q <= DET_WOKEN;
				DET_WOKEN: detState_q <= DET_WOKEN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Silence timer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			silenceCnt_q <= '0;
		end else if (busEvents.busEdge || silenceExpire || !(swkRun || detState_q == DET_PAT2)) begin
			silenceCnt_q <= '0;
		end else begin
			silenceCnt_q <= silenceCnt_q + 32'd1;
		end
	end

	// ----------------------------------------------------------------
	// Protocol error counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ecnt_q <= selwake_pkg::ECNT_ZERO;
		end else if (checkOk || rearm || (detState_q == DET_FRAME && silenceExpire)) begin
			ecnt_q <= selwake_pkg::ECNT_ZERO;
		end else if (detState_q == DET_WOKEN) begin
			ecnt_q <= ecnt_q;
		end else if ((detState_q == DET_FRAME) || modeBits_q[1]) begin
			if (busEvents.protoError) begin
				ecnt_q <= ecnt_q + 6'd1;
			end else if (busEvents.validFrame && (ecnt_q != selwake_pkg::ECNT_ZERO)) begin
				ecnt_q <= ecnt_q - 6'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status and wake flags (hardware set wins over software clear)
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			powerOn_q <= 1'b1;
			fail_q <= 1'b0;
			chanWake_q <= 1'b0;
		end else begin
			if (busWr && (idx == selwake_pkg::IDX_STATUS)) begin
				powerOn_q <= powerOn_q & ~avs_writedata[selwake_pkg::ST_POR];
			end
			fail_q <= (fail_q & ~(busWr && (idx == selwake_pkg::IDX_STATUS) &&
				avs_writedata[selwake_pkg::ST_FAIL])) |
				busEvents.busDomTimeout | busEvents.txdDomTimeout;
			chanWake_q <= (chanWake_q & ~(busWr && (idx == selwake_pkg::IDX_WKSTAT) &&
				avs_writedata[selwake_pkg::WK_CHAN])) | anyWake;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			patWake_q <= 1'b0;
			frameWake_q <= 1'b0;
		end else begin
			patWake_q <= (patWake_q & ~rearm) | patDet1 | patWakeSwk | patWakeWk;
			frameWake_q <= (frameWake_q & ~rearm) | frameWakeEv;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sysErr_q <= 1'b0;
		end else if ((checkRun && !cfgValid_q) || ecntOverflow || cfgErr || restartErr) begin
			sysErr_q <= 1'b1;
		end else if (checkOk) begin
			sysErr_q <= 1'b0;
		end else if (errClrReq && !(modeBits_q[2] && !cfgValid_q)) begin
			sysErr_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busTimeout_q <= 1'b0;
			silence_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			busTimeout_q <= (busTimeout_q & ~(busWr && (idx == selwake_pkg::IDX_SWKSTAT) &&
				avs_writedata[selwake_pkg::SW_TO])) | silenceExpire;
			if (silenceExpire) begin
				silence_q <= 1'b1;
			end else if (busEvents.wupSeen) begin
				silence_q <= 1'b0;
			end
			if (!chanOn) begin
				sync_q <= 1'b0;
			end else if (busEvents.protoError) begin
				sync_q <= 1'b0;
			end else if (busEvents.validFrame) begin
				sync_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
		end else if (checkRun || cfgErr || restartErr ||
			(!anyWake && (detState_q == DET_PAT2) && sysErr_q && !armed_q && modeBits_q[2])) begin
			armed_q <= 1'b1;
		end else if (anyWake || (modeWr && !modeWrVal[2])) begin
			armed_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Configuration valid and control
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgValid_q <= 1'b0;
			toMask_q <= 1'b0;
			wokeByFrame_q <= 1'b0;
		end else begin
			if (cfgWr || enterRestart || frameWakeEv || patWakeSwk || ecntOverflow) begin
				cfgValid_q <= 1'b0;
			end else if (swCtrlWr) begin
				cfgValid_q <= avs_writedata[selwake_pkg::CT_VALID];
			end
			if (swCtrlWr) begin
				toMask_q <= avs_writedata[selwake_pkg::CT_TOMASK];
			end
			if (frameWakeEv && (sbcMode == selwake_pkg::SBC_SLEEP)) begin
				wokeByFrame_q <= 1'b1;
			end else if (rearm || (sbcMode == selwake_pkg::SBC_NORMAL)) begin
				wokeByFrame_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs to the rest of the chip
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wakeIrq_q <= 1'b0;
			timeoutIrq_q <= 1'b0;
			restartReq_q <= 1'b0;
		end else begin
			wakeIrq_q <= anyWake && awake;
			restartReq_q <= anyWake && (sbcMode == selwake_pkg::SBC_SLEEP);
			// Expiry pulses only with toMask_q set in Normal or Stop, flag state ignored; sleep is never woken by it
			timeoutIrq_q <= silenceExpire && toMask_q && awake;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txEn_q <= 1'b0;
			rxDel_q <= 1'b0;
			rxLow_q <= 1'b0;
			swkAct_q <= 1'b0;
		end else begin
			txEn_q <= inNormal && (modeBits_q[1:0] == selwake_pkg::LOW_NORMAL);
			rxDel_q <= awake && modeBits_q[1];
			// Receive output only signals wake in modes that do not carry bus data
			rxLow_q <= (detState_q == DET_WOKEN) && !modeBits_q[1];
			swkAct_q <= swkRun;
		end
	end

	assign avs_readdata = readData_q;
	assign avs_waitrequest = waitReq_q;
	assign wakeIrq = wakeIrq_q;
	assign timeoutIrq = timeoutIrq_q;
	assign restartReq = restartReq_q;
	assign transmitEnable = txEn_q;
	assign receiveDeliver = rxDel_q;
	assign receiveWakeLow = rxLow_q;
	assign swkActive = swkAct_q;

endmodule // can_selective_wake_flags

// *** verification/selwake_flags_props.sv ***
// Concurrent port checks for the selective-wake flag block
`timescale 1ns/1ps
module selwake_flags_props #(
	parameter int unsigned SILENCE_CYCLES = 200000,
	parameter int ADDR_W = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire selwake_pkg::sbc_mode_t sbcMode,
	input wire selwake_pkg::bus_events_t busEvents,
	input wire logic wakeIrq,
	input wire logic timeoutIrq,
	input wire logic restartReq,
	input wire logic transmitEnable,
	input wire logic receiveDeliver,
	input wire logic receiveWakeLow,
	input wire logic swkActive
);
	// ----------------------------------------------------------------
	// Clocking and access steps
	// ----------------------------------------------------------------
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_request;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// One wait state, then the slave drops back to busy
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_access_one_wait:
		assert property (s_request |=> s_answer) else $error("bus answer not one wait state");
	a_idle_wait_high:
		assert property (!(avs_read || avs_write) |-> avs_waitrequest) else $error("idle ready");
	a_sleep_no_timeout:
		assert property ((sbcMode == selwake_pkg::SBC_SLEEP) |=> !timeoutIrq)
		else $error("timeout interrupt in sleep");
	a_sleep_no_wakeirq:
		assert property ((sbcMode == selwake_pkg::SBC_SLEEP) |=> !wakeIrq)
		else $error("wake interrupt in sleep");
	a_restart_only_sleep:
		assert property ((sbcMode != selwake_pkg::SBC_SLEEP) |=> !restartReq)
		else $error("restart request outside sleep");
	a_tx_normal_only:
		assert property ((sbcMode != selwake_pkg::SBC_NORMAL) |=> !transmitEnable)
		else $error("transmit outside normal");
	a_rx_sleep_off:
		assert property ((sbcMode == selwake_pkg::SBC_SLEEP) |=> !receiveDeliver)
		else $error("receive data in sleep");
	a_timeout_irq_pulse:
		assert property ($rose(timeoutIrq) |=> !timeoutIrq) else $error("timeout pulse too long");
endmodule // selwake_flags_props

bind can_selective_wake_flags selwake_flags_props #(
	.SILENCE_CYCLES(SILENCE_CYCLES), .ADDR_W(ADDR_W)) props (
	.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .sbcMode(sbcMode), .busEvents(busEvents),
	.wakeIrq(wakeIrq), .timeoutIrq(timeoutIrq), .restartReq(restartReq),
	.transmitEnable(transmitEnable), .receiveDeliver(receiveDeliver),
	.receiveWakeLow(receiveWakeLow), .swkActive(swkActive));

// *** verification/can_node_model.sv ***
// Behavioural bus node turning bench requests into one-cycle bus event pulses
`timescale 1ns/1ps
module can_node_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [6:0] request,
	output selwake_pkg::bus_events_t busEvents
);
	// Real traffic always carries edges, so every event also restarts the silence count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busEvents <= '0;
		end else begin
			busEvents <= selwake_pkg::bus_events_t'(request | {4'h0, |request, 2'h0});
		end
	end
endmodule // can_node_model

// *** verification/test_can_selective_wake_flags.sv ***
// Self-checking bench for the selective-wake flag block
`timescale 1ns/1ps
`define CHECK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin errors++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module test_can_selective_wake_flags;
	localparam int SIL = 60;
	localparam logic [6:0] E_WUP = 7'h40, E_FRM = 7'h20, E_VAL = 7'h10, E_ERR = 7'h08;
	logic clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, avsWait;
	logic [8:0] avsAddr = 9'h000;
	logic [31:0] avsWdata = 32'h0000_0000, avsRdata, got;
	logic [6:0] evReq = 7'h00;
	selwake_pkg::sbc_mode_t sbcMode = selwake_pkg::SBC_NORMAL;
	selwake_pkg::bus_events_t busEvents;
	logic wakeIrq, timeoutIrq, restartReq, transmitEnable, receiveDeliver, swkActive;
	logic receiveWakeLow;
	int errors = 0, totalChecks = 0, wakeCnt = 0, toCnt = 0, rstCnt = 0;
	always #2.5 clk = ~clk;
	can_node_model node (.clk(clk), .rst_n(rst_n), .request(evReq), .busEvents(busEvents));
	can_selective_wake_flags #(.SILENCE_CYCLES(SIL), .ADDR_W(9)) DUT (
		.clk(clk), .rst_n(rst_n), .avs_address(avsAddr), .avs_read(avsRead),
		.avs_write(avsWrite), .avs_writedata(avsWdata), .avs_readdata(avsRdata),
		.avs_waitrequest(avsWait), .sbcMode(sbcMode), .busEvents(busEvents),
		.wakeIrq(wakeIrq), .timeoutIrq(timeoutIrq), .restartReq(restartReq),
		.transmitEnable(transmitEnable), .receiveDeliver(receiveDeliver),
		.receiveWakeLow(receiveWakeLow), .swkActive(swkActive));
	// Output pulses last one cycle, so they are counted rather than polled
	always @(posedge clk) begin
		wakeCnt += (wakeIrq === 1'b1);
		toCnt += (timeoutIrq === 1'b1);
		rstCnt += (restartReq === 1'b1);
	end
	// ----------------------------------------------------------------
	// Bus and event tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", totalChecks, errors);
		if (errors == 0 && totalChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic access(input logic w, input logic [6:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avsAddr <= {idx, 2'b00};
		avsWrite <= w;
		avsRead <= !w;
		avsWdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avsWait !== 1'b0 && n < 20);
		got = avsRdata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		if (avsWait !== 1'b0) begin
			errors++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [6:0] idx, input logic [31:0] d);
		access(1'b1, idx, d);
	endtask
	task automatic rd(input logic [6:0] idx, input logic [31:0] exp);
		access(1'b0, idx, 32'h0000_0000);
		`CHECK(got, exp)
	endtask
	task automatic ev(input logic [6:0] e);
		@(posedge clk);
		evReq <= e;
		@(posedge clk);
		evReq <= 7'h00;
		repeat (3) @(posedge clk);
	endtask
	task automatic mode(input selwake_pkg::sbc_mode_t m);
		@(posedge clk);
		sbcMode <= m;
	endtask
	task automatic done(input string s);
		$display("Test %s finished, %0d mismatches so far", s, errors);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(selwake_pkg::IDX_STATUS, 32'h1);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h0);
		rd(selwake_pkg::IDX_SWKCTRL, 32'h0);
		rd(7'h10, 32'h0);
		wr(selwake_pkg::IDX_STATUS, 32'h1);
		rd(selwake_pkg::IDX_STATUS, 32'h0);
		for (int i = 0; i < 2; i++) begin
			ev(7'h1 << i);
			rd(selwake_pkg::IDX_STATUS, 32'h2);
			wr(selwake_pkg::IDX_STATUS, 32'h2);
		end
		// Modes 5 to 7 run the check with config invalid, so they settle in pattern state two
		for (int m = 0; m < 8; m++) begin
			wr(selwake_pkg::IDX_BUSCTRL, m);
			rd(selwake_pkg::IDX_BUSCTRL, m);
			`CHECK({transmitEnable, receiveDeliver}, {m[1:0] == 2'h3, m[1]})
		end
		done("reset_and_modes");
		wr(selwake_pkg::IDX_BUSCTRL, 32'h5);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h44);
		wr(selwake_pkg::IDX_SWKSTAT, 32'h4);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h44);
		`CHECK(swkActive, 1'b0)
		ev(E_WUP);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h05);
		rd(selwake_pkg::IDX_WKSTAT, 32'h1);
		`CHECK(wakeCnt, 1)
		`CHECK(receiveWakeLow, 1'b1)
		wr(selwake_pkg::IDX_BUSCTRL, 32'h0);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h04);
		wr(selwake_pkg::IDX_SWKCTRL, 32'h1);
		wr(selwake_pkg::IDX_SWKSTAT, 32'h4);
		wr(selwake_pkg::IDX_WKSTAT, 32'h1);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h0);
		wr(selwake_pkg::IDX_BUSCTRL, 32'h7);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h40);
		`CHECK({swkActive, transmitEnable, receiveDeliver}, 3'h7)
		ev(E_VAL);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h60);
		ev(E_ERR);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h40);
		rd(selwake_pkg::IDX_ECNT, 32'h1);
		ev(E_FRM);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h02);
		rd(selwake_pkg::IDX_WKSTAT, 32'h1);
		`CHECK(wakeCnt, 2)
		`CHECK(receiveWakeLow, 1'b0)
		wr(selwake_pkg::IDX_BUSCTRL, 32'h0);
		wr(selwake_pkg::IDX_WKSTAT, 32'h1);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h0);
		done("config_and_wake");
		wr(selwake_pkg::IDX_SWKCTRL, 32'h3);
		wr(selwake_pkg::IDX_BUSCTRL, 32'h7);
		ev(7'h04);
		repeat (SIL / 2) @(posedge clk);
		`CHECK(toCnt, 0)
		repeat (SIL) @(posedge clk);
		`CHECK(toCnt, 1)
		rd(selwake_pkg::IDX_SWKSTAT, 32'h58);
		wr(selwake_pkg::IDX_SWKSTAT, 32'h8);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h50);
		ev(E_WUP);
		rd(selwake_pkg::IDX_SWKSTAT, 32'h41);
		`CHECK(wakeCnt, 2)
		done("silence");
		mode(selwake_pkg::SBC_STOP);
		wr(selwake_pkg::IDX_BUSCTRL, 32'h0);
		// Normal with selective wake drops to wake-capable with selective wake in Stop
		rd(selwake_pkg::IDX_BUSCTRL, 32'h5);
		`CHECK({transmitEnable, receiveDeliver}, 2'h0)
		wr(selwake_pkg::IDX_CFG_FIRST, 32'h1);
		rd(selwake_pkg::IDX_SWKCTRL, 32'h3);
		mode(selwake_pkg::SBC_NORMAL);
		wr(selwake_pkg::IDX_CFG_LAST, 32'h1);
		rd(selwake_pkg::IDX_SWKCTRL, 32'h2);
		access(1'b0, selwake_pkg::IDX_SWKSTAT, 32'h0);
		`CHECK(got[2], 1'b1)
		done("low_power_writes");
		wr(selwake_pkg::IDX_BUSCTRL, 32'h0);
		wr(selwake_pkg::IDX_SWKCTRL, 32'h3);
		wr(selwake_pkg::IDX_SWKSTAT, 32'h4);
		wr(selwake_pkg::IDX_BUSCTRL, 32'h5);
		mode(selwake_pkg::SBC_SLEEP);
		ev(E_FRM);
		`CHECK({rstCnt, wakeCnt}, {32'd1, 32'd2})
		mode(selwake_pkg::SBC_RESTART);
		repeat (2) @(posedge clk);
		rd(selwake_pkg::IDX_SWKCTRL, 32'h2);
		access(1'b0, selwake_pkg::IDX_SWKSTAT, 32'h0);
		`CHECK(got[2:1], 2'h1)
		done("sleep_restart");
		mode(selwake_pkg::SBC_NORMAL);
		wr(selwake_pkg::IDX_BUSCTRL, 32'h0);
		wr(selwake_pkg::IDX_SWKCTRL, 32'h1);
		wr(selwake_pkg::IDX_BUSCTRL, 32'h7);
		repeat (31) ev(E_ERR);
		rd(selwake_pkg::IDX_ECNT, 32'h1f);
		ev(E_ERR);
		rd(selwake_pkg::IDX_ECNT, 32'h20);
		access(1'b0, selwake_pkg::IDX_SWKSTAT, 32'h0);
		`CHECK({got[2], wakeCnt}, {1'b1, 32'd3})
		done("counter_overflow");
		tally_and_finish();
	end
endmodule // test_can_selective_wake_flags
